// file: lcc_pkg.sv
package lcc_pkg;
  localparam int CELLS    = 10;
  localparam int LUT_IN   = 4;
  localparam int LUT_BITS = 16;
  localparam int GLOBALS  = 4;
  localparam int GP_PINS  = 2;
  localparam int SEL_W    = 4;
  localparam int PIN_SYNC = GLOBALS + GP_PINS;
  // Index of the second cell, where the chains start
  localparam int CHAIN_FIRST = 1;
  // Source select codes: globals, then pins, then cell table outputs
  localparam logic [SEL_W-1:0] SRC_PIN_BASE  = 4'h4;
  localparam logic [SEL_W-1:0] SRC_CELL_BASE = 4'h6;
  // Data input roles
  localparam int OPA_BIT  = 0;
  localparam int OPB_BIT  = 1;
  localparam int LOAD_BIT = 2;
  localparam int K_BIT    = 3;
  localparam logic Q_RESET = 1'b0;

  typedef enum logic [1:0] {
    LCC_FF_D  = 2'b00,
    LCC_FF_T  = 2'b01,
    LCC_FF_JK = 2'b10,
    LCC_FF_SR = 2'b11
  } lcc_ff_mode_e;
endpackage

// file: lcc_cell.sv
module lcc_cell (
  input  wire logic                          ref_clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic [lcc_pkg::LUT_BITS-1:0]  lut_mask_in,
  input  wire logic [lcc_pkg::LUT_IN-1:0]    data_in,
  input  wire lcc_pkg::lcc_ff_mode_e         ff_mode_in,
  input  wire logic                          bypass_in,
  input  wire logic                          carry_en_in,
  input  wire logic                          casc_en_in,
  input  wire logic                          casc_or_in,
  input  wire logic                          carry_in,
  input  wire logic                          cascade_in,
  input  wire logic                          clk_edge_in,
  input  wire logic                          clear_in,
  input  wire logic                          sync_clr_in,
  input  wire logic                          sync_ld_in,
  output logic                               lut_out,
  output logic                               carry_out,
  output logic                               cascade_out,
  output logic                               local_out,
  output logic                               row_col_out
);
  import lcc_pkg::*;

  typedef struct packed {
    logic q;
  } lcc_cell_s;

  lcc_cell_s state;
  lcc_cell_s next_state;
  logic      sum;
  logic      func;
  logic      ff_b;
  logic      q_upd;
  logic      cell_val;

  assign lut_out = lut_mask_in[data_in];

  always_comb begin
    sum = carry_en_in ? (lut_out ^ carry_in) : lut_out;
    if (casc_en_in) begin
      // OR form is the inverted AND of inverted inputs
      func = casc_or_in ? ~(~sum & ~cascade_in) : (sum & cascade_in);
    end else begin
      func = sum;
    end
    ff_b = data_in[K_BIT];
    case (ff_mode_in)
      LCC_FF_D:  q_upd = func;
      LCC_FF_T:  q_upd = state.q ^ func;
      LCC_FF_JK: q_upd = (func & ~state.q) | (~ff_b & state.q);
      // Set wins when both set and reset are high
      LCC_FF_SR: q_upd = func | (~ff_b & state.q);
      default:   q_upd = func;
    endcase
    next_state = state;
    if (clear_in) begin
      next_state.q = Q_RESET;
    end else if (clk_edge_in) begin
      if (sync_clr_in) begin
        next_state.q = Q_RESET;
      end else if (sync_ld_in) begin
        next_state.q = data_in[LOAD_BIT];
      end else begin
        next_state.q = q_upd;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign carry_out = carry_en_in &
      ((data_in[OPA_BIT] & data_in[OPB_BIT]) | (data_in[OPA_BIT] & carry_in) |
       (data_in[OPB_BIT] & carry_in));
  assign cascade_out = func;
  // Clear masks the register output at once, not only at the next edge; a bypassed cell is not masked
  assign cell_val    = bypass_in ? func : (clear_in ? Q_RESET : state.q);
  assign local_out   = cell_val;
  assign row_col_out = cell_val;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_bypass_path: assert property (
    (bypass_in && !carry_en_in && !casc_en_in) |-> (local_out == lut_mask_in[data_in]))
    else $error("bypassed cell does not show its table result");
  a_clear_force: assert property (
    (!bypass_in && clear_in) |-> (local_out == 1'b0) ##1 (state.q == 1'b0))
    else $error("clear did not force the register to zero");
  a_d_capture: assert property (
    (clk_edge_in && !clear_in && !sync_clr_in && !sync_ld_in && ff_mode_in == LCC_FF_D)
      |=> (state.q == $past(func)))
    else $error("D register missed its input on the clock edge");
  a_t_toggle: assert property (
    (clk_edge_in && !clear_in && !sync_clr_in && !sync_ld_in && ff_mode_in == LCC_FF_T
     && func) |=> (state.q != $past(state.q)))
    else $error("T register did not toggle");
  a_hold_between: assert property (
    (!clk_edge_in && !clear_in) |=> $stable(state.q))
    else $error("register changed without a selected clock edge");
  a_cascade_or: assert property (
    (casc_en_in && casc_or_in && !carry_en_in && cascade_in) |-> cascade_out)
    else $error("OR cascade lost an incoming one");
endmodule // lcc_cell

// file: lcc_cluster.sv
// Overview of operation
// - Every cell has a four-input table that can hold any function of its four inputs.
// - Every cell has one register; cells two to ten have direct carry and cascade links to their neighbour.
// - Ten cells form a cluster with chains, cluster-wide controls and a local interconnect.
// - The cell register works as a D, T, JK or SR flip-flop by configuration.
// - Register clock and clear each come from a global line, a pin or any cell's logic.
// - In combinational use the register is bypassed and the table result drives the outputs.
// - A cell output drives the local and the row and column interconnect together.
// - Four global inputs on low-skew routing feed the register controls everywhere.
// - Internal logic may drive each global line, for example a divided clock or a clear.
// - The chains link cells two to ten and carry on across clusters in the same half row.
// - The carry chain serves counters and adders; the cascade chain builds wide functions.
// - A cascade link joins neighbours by AND, or by OR through inversion.
// - The first cell may make cluster controls and is kept out of the cascade chain.
// - Cluster-wide synchronous clear or load acts on every register of the cluster.
module lcc_cluster (
  input  wire logic                                       ref_clk_in,
  input  wire logic                                       sys_rst_in,
  input  wire logic [lcc_pkg::GLOBALS-1:0]                global_pin_in,
  input  wire logic [lcc_pkg::GP_PINS-1:0]                gp_pin_in,
  input  wire logic [lcc_pkg::GLOBALS-1:0]                global_int_in,
  input  wire logic [lcc_pkg::GLOBALS*lcc_pkg::SEL_W-1:0] global_cell_sel_in,
  input  wire logic [lcc_pkg::CELLS*lcc_pkg::LUT_BITS-1:0] lut_mask_in,
  input  wire logic [lcc_pkg::CELLS*lcc_pkg::LUT_IN-1:0]  data_in,
  input  wire logic [lcc_pkg::CELLS*2-1:0]                ff_mode_in,
  input  wire logic [lcc_pkg::CELLS-1:0]                  bypass_in,
  input  wire logic [lcc_pkg::CELLS-1:0]                  carry_en_in,
  input  wire logic [lcc_pkg::CELLS-1:0]                  casc_en_in,
  input  wire logic [lcc_pkg::CELLS-1:0]                  casc_or_in,
  input  wire logic [lcc_pkg::CELLS*lcc_pkg::SEL_W-1:0]   clk_sel_in,
  input  wire logic [lcc_pkg::CELLS*lcc_pkg::SEL_W-1:0]   clr_sel_in,
  input  wire logic                                       sclr_en_in,
  input  wire logic [lcc_pkg::SEL_W-1:0]                  sclr_sel_in,
  input  wire logic                                       sld_en_in,
  input  wire logic [lcc_pkg::SEL_W-1:0]                  sld_sel_in,
  input  wire logic                                       carry_chain_in,
  input  wire logic                                       cascade_chain_in,
  output logic                                            carry_chain_out,
  output logic                                            cascade_chain_out,
  output logic [lcc_pkg::CELLS-1:0]                       local_out,
  output logic [lcc_pkg::CELLS-1:0]                       row_col_out,
  output logic [lcc_pkg::GLOBALS-1:0]                     global_line_out
);
  import lcc_pkg::*;

  typedef struct packed {
    logic [PIN_SYNC-1:0] pin_s1;
    logic [PIN_SYNC-1:0] pin_s2;
    logic [CELLS-1:0]    clk_prev;
  } lcc_cluster_s;

  lcc_cluster_s         state;
  lcc_cluster_s         next_state;
  logic [GLOBALS-1:0]   global_line;
  logic [GP_PINS-1:0]   gp_sync;
  logic [CELLS-1:0]     cell_lut;
  logic [CELLS-1:0]     sel_clk;
  logic [CELLS-1:0]     sel_clr;
  logic [CELLS-1:0]     clk_edge;
  logic [CELLS-1:0]     carry_link;
  logic [CELLS-1:0]     casc_link;
  logic                 sclr_act;
  logic                 sld_act;

  // Out-of-range cell indices read as zero rather than X
  function automatic logic lut_pick(input logic [SEL_W-1:0] idx,
                                    input logic [CELLS-1:0] lut);
    logic r;
    r = 1'b0;
    if (idx < CELLS) begin
      r = lut[idx];
    end
    return r;
  endfunction

  // Internal sources are table outputs, so no select can close a loop
  function automatic logic pick_src(input logic [SEL_W-1:0]   sel,
                                    input logic [GLOBALS-1:0] gl,
                                    input logic [GP_PINS-1:0] gp,
                                    input logic [CELLS-1:0]   lut);
    logic r;
    if (sel < SRC_PIN_BASE) begin
      r = gl[sel[1:0]];
    end else if (sel < SRC_CELL_BASE) begin
      r = gp[sel[0]];
    end else begin
      r = lut_pick(sel - SRC_CELL_BASE, lut);
    end
    return r;
  endfunction

  assign gp_sync = state.pin_s2[GLOBALS +: GP_PINS];

  for (genvar g = 0; g < GLOBALS; g++) begin : g_global
    assign global_line[g] = global_int_in[g] ?
        lut_pick(global_cell_sel_in[g*SEL_W +: SEL_W], cell_lut) : state.pin_s2[g];
  end
  assign global_line_out = global_line;

  assign sclr_act = sclr_en_in & pick_src(sclr_sel_in, global_line, gp_sync, cell_lut);
  assign sld_act  = sld_en_in & pick_src(sld_sel_in, global_line, gp_sync, cell_lut);

  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    logic cin;
    logic casc_in;
    logic casc_en;
    logic carry_en;
    if (i == 0) begin : g_first
      assign cin      = 1'b0;
      assign casc_in  = 1'b0;
      assign casc_en  = 1'b0;
      assign carry_en = 1'b0;
    end else if (i == CHAIN_FIRST) begin : g_head
      assign cin      = carry_chain_in;
      assign casc_in  = cascade_chain_in;
      assign casc_en  = casc_en_in[i];
      assign carry_en = carry_en_in[i];
    end else begin : g_body
      assign cin      = carry_link[i-1];
      assign casc_in  = casc_link[i-1];
      assign casc_en  = casc_en_in[i];
      assign carry_en = carry_en_in[i];
    end
    assign sel_clk[i] = pick_src(clk_sel_in[i*SEL_W +: SEL_W], global_line, gp_sync,
                                 cell_lut);
    assign sel_clr[i] = pick_src(clr_sel_in[i*SEL_W +: SEL_W], global_line, gp_sync,
                                 cell_lut);
    assign clk_edge[i] = sel_clk[i] & ~state.clk_prev[i];

    lcc_cell u_cell (
      .ref_clk_in  (ref_clk_in),
      .sys_rst_in  (sys_rst_in),
      .lut_mask_in (lut_mask_in[i*LUT_BITS +: LUT_BITS]),
      .data_in     (data_in[i*LUT_IN +: LUT_IN]),
      .ff_mode_in  (lcc_ff_mode_e'(ff_mode_in[i*2 +: 2])),
      .bypass_in   (bypass_in[i]),
      .carry_en_in (carry_en),
      .casc_en_in  (casc_en),
      .casc_or_in  (casc_or_in[i]),
      .carry_in    (cin),
      .cascade_in  (casc_in),
      .clk_edge_in (clk_edge[i]),
      .clear_in    (sel_clr[i]),
      .sync_clr_in (sclr_act),
      .sync_ld_in  (sld_act),
      .lut_out     (cell_lut[i]),
      .carry_out   (carry_link[i]),
      .cascade_out (casc_link[i]),
      .local_out   (local_out[i]),
      .row_col_out (row_col_out[i])
    );

    a_sync_clear_all: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (sclr_act && clk_edge[i] && !bypass_in[i]) |=> (bypass_in[i] || local_out[i] == 1'b0))
      else $error("cluster clear missed a register");
    // Edge detector starts from zero, so the first edge after reset is left out
    a_clock_select: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (!$past(sys_rst_in) && !(sel_clk[i] && !$past(sel_clk[i])) && !sel_clr[i] &&
       !bypass_in[i]) |=> (sel_clr[i] || bypass_in[i] || $stable(local_out[i])))
      else $error("register moved without a rise of its selected clock");
    a_clear_from_pin: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (clr_sel_in[i*SEL_W +: SEL_W] == SRC_PIN_BASE && gp_sync[0] && !bypass_in[i]) |->
        !local_out[i])
      else $error("cell not cleared by the pin chosen as its clear");
    a_sync_load_all: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (sld_act && !sclr_act && clk_edge[i] && !sel_clr[i]) |=>
        (bypass_in[i] || sel_clr[i] ||
         local_out[i] == $past(data_in[i*LUT_IN + LOAD_BIT])))
      else $error("cluster load missed a register");
  end

  assign carry_chain_out   = carry_link[CELLS-1];
  assign cascade_chain_out = casc_link[CELLS-1];

  // Chains enter at the second cell; the first cell stays out of them
  a_carry_head: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (carry_en_in[CHAIN_FIRST] &&
     (data_in[CHAIN_FIRST*LUT_IN + OPA_BIT] ^ data_in[CHAIN_FIRST*LUT_IN + OPB_BIT])) |->
      carry_link[CHAIN_FIRST] == carry_chain_in)
    else $error("carry chain input did not reach the second cell");
  a_casc_head: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (casc_en_in[CHAIN_FIRST] && !casc_or_in[CHAIN_FIRST] && !carry_en_in[CHAIN_FIRST]) |->
      casc_link[CHAIN_FIRST] == (cell_lut[CHAIN_FIRST] & cascade_chain_in))
    else $error("first cell leaked into the cascade chain");
  a_carry_tail: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    (carry_en_in[CELLS-1] &&
     (data_in[(CELLS-1)*LUT_IN + OPA_BIT] ^ data_in[(CELLS-1)*LUT_IN + OPB_BIT])) |->
      carry_chain_out == carry_link[CELLS-2])
    else $error("carry chain did not leave from the last cell");

  always_comb begin
    next_state = state;
    // Pins are asynchronous: two stages before any logic
    next_state.pin_s1   = {gp_pin_in, global_pin_in};
    next_state.pin_s2   = state.pin_s1;
    next_state.clk_prev = sel_clk;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  for (genvar g = 0; g < GLOBALS; g++) begin : g_gchk
    a_global_internal: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      global_int_in[g] |->
        global_line_out[g] == lut_pick(global_cell_sel_in[g*SEL_W +: SEL_W], cell_lut))
      else $error("global line not driven by selected cell");
    a_global_pin: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (!global_int_in[g] && !$past(sys_rst_in, 2)) |->
        global_line_out[g] == $past(global_pin_in[g], 2))
      else $error("global pin not delayed by two stages");
    a_global_range: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (global_int_in[g] && global_cell_sel_in[g*SEL_W +: SEL_W] >= CELLS) |->
        !global_line_out[g])
      else $error("out of range cell select did not read as zero");
  end
endmodule // lcc_cluster

// file: lcc_fabric.sv
module lcc_fabric (
  input  wire logic       ref_clk_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] req_in,
  output logic      [7:0] line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held;
  // A far neighbour answers one cycle late
  always @(posedge ref_clk_in) held <= req_in;
  // Slow mode hands on the late copy of every bit; otherwise requests pass straight through
  assign line_out = slow_in ? held : req_in;
endmodule // lcc_fabric

// file: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import lcc_pkg::*;
  logic         ref_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         slow    = 1'b1;
  logic [7:0]   req     = 8'h00;
  logic [7:0]   line;
  logic [3:0]   gint    = 4'h0;
  logic [15:0]  gsel    = 16'h0000;
  logic [159:0] mask    = {10{16'haaaa}};
  logic [39:0]  data    = 40'h0;
  logic [19:0]  mode    = 20'h0;
  logic [9:0]   byp     = 10'h001;
  logic [9:0]   cen     = 10'h000;
  logic [9:0]   sen     = 10'h000;
  logic [9:0]   sor     = 10'h000;
  logic [39:0]  csel    = {10{4'h6}};
  logic [39:0]  rsel    = {10{4'h4}};
  logic         cco;
  logic         sco;
  logic [9:0]   loc;
  logic [9:0]   rc;
  logic [3:0]   gl;
  logic [9:0]   q       = 10'h000;
  logic [9:0]   ev;
  int           n_errors    = 0;
  int           checks_done = 0;

  always #25 ref_clk = ~ref_clk;

  lcc_fabric u_lcc_fabric (.ref_clk_in(ref_clk), .slow_in(slow), .req_in(req), .line_out(line));

  lcc_cluster u_lcc_cluster (
    .ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .global_pin_in(line[5:2]),
    .gp_pin_in(line[7:6]), .global_int_in(gint), .global_cell_sel_in(gsel),
    .lut_mask_in(mask), .data_in(data), .ff_mode_in(mode), .bypass_in(byp),
    .carry_en_in(cen), .casc_en_in(sen), .casc_or_in(sor), .clk_sel_in(csel),
    .clr_sel_in(rsel), .sclr_en_in(1'b1), .sclr_sel_in(4'h1), .sld_en_in(1'b1),
    .sld_sel_in(4'h5), .carry_chain_in(line[0]), .cascade_chain_in(line[1]),
    .carry_chain_out(cco), .cascade_chain_out(sco), .local_out(loc),
    .row_col_out(rc), .global_line_out(gl)
  );

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  // Source goes high, then low, each long enough to cross the pin sync
  task automatic pulse;
    data[0] = 1'b1;
    req[2]  = 1'b1;
    step(5);
    data[0] = 1'b0;
    req[2]  = 1'b0;
    step(5);
  endtask

  task automatic chk_cells;
    chk({6'h00, loc}, {6'h00, q}, "local");
    chk({6'h00, rc}, {6'h00, q}, "row col");
  endtask

  task automatic do_load;
    for (int i = 1; i < CELLS; i++) begin
      data[4*i+2] = i[0];
      q[i] = i[0];
    end
    req[7] = 1'b1;
    step(4);
    pulse();
    req[7] = 1'b0;
    step(4);
  endtask

  function automatic logic nxt(input logic [1:0] m, input logic f, input logic k,
                               input logic c);
    case (m)
      2'b00: return f;
      2'b01: return c ^ f;
      2'b10: return f ? (k ? ~c : 1'b1) : (k ? 1'b0 : c);
      default: return f ? 1'b1 : (k ? 1'b0 : c);
    endcase
  endfunction

  initial begin
    for (int i = 1; i < CELLS; i++) mode[2*i +: 2] = 2'((i - 1) / 2);
    step(6);
    sys_rst = 1'b0;
    chk_cells();
    for (int p = 0; p < 4; p++) begin
      for (int i = 1; i < CELLS; i++) begin
        data[4*i +: 4] = {p[1], 2'b00, p[0] ^ i[0]};
        q[i] = nxt(mode[2*i +: 2], p[0] ^ i[0], p[1], q[i]);
      end
      pulse();
      chk_cells();
    end
    do_load();
    chk_cells();
    req[6] = 1'b1;
    step(4);
    q = 10'h000;
    chk_cells();
    req[6] = 1'b0;
    step(4);
    chk_cells();
    do_load();
    req[3] = 1'b1;
    step(4);
    pulse();
    q = 10'h000;
    chk_cells();
    req[3] = 1'b0;
    step(4);
    mode = 20'h0;
    csel = {10{4'h0}};
    for (int i = 1; i < CELLS; i++) data[4*i] = 1'b1;
    q = 10'h3fe;
    pulse();
    chk_cells();
    slow = 1'b0;
    byp = 10'h3ff;
    for (int i = 0; i < CELLS; i++) mask[16*i +: 16] = 16'h6996 ^ {4{4'(i)}};
    for (int d = 0; d < 16; d++) begin
      data = {10{4'(d)}};
      step(1);
      for (int i = 0; i < CELLS; i++) ev[i] = mask[16*i + d];
      chk({6'h00, loc}, {6'h00, ev}, "table");
      chk({6'h00, rc}, {6'h00, ev}, "table rc");
    end
    gint = 4'h8;
    req[5:2] = 4'h5;
    step(3);
    chk({12'h000, gl}, {12'h000, mask[15], 3'b101}, "globals");
    gsel = 16'hf000;
    step(1);
    chk({12'h000, gl}, {12'h000, 4'h5}, "global range");
    cen = 10'h3ff;
    data = {10{4'h1}};
    for (int v = 0; v < 2; v++) begin
      req[0] = v[0];
      step(1);
      chk({15'h0, cco}, {15'h0, v[0]}, "carry pass");
    end
    data[23:20] = 4'h0;
    step(1);
    chk({15'h0, cco}, 16'h0000, "carry kill");
    req[0] = 1'b0;
    data[23:20] = 4'h3;
    step(1);
    chk({15'h0, cco}, 16'h0001, "carry make");
    cen = 10'h000;
    sen = 10'h3ff;
    mask = {{9{16'hffff}}, 16'h0000};
    req[1] = 1'b1;
    step(1);
    chk({15'h0, sco}, 16'h0001, "and chain");
    mask[79:64] = 16'h0000;
    step(1);
    chk({15'h0, sco}, 16'h0000, "and chain low");
    sor = 10'h3ff;
    mask = {{9{16'h0000}}, 16'hffff};
    req[1] = 1'b0;
    step(1);
    chk({15'h0, sco}, 16'h0000, "or chain");
    mask[127:112] = 16'hffff;
    step(1);
    chk({15'h0, sco}, 16'h0001, "or chain high");
    print_verdict();
  end

  initial begin
    #200000;
    n_errors++;
    $display("MISMATCH t=%0t run did not finish", $time);
    print_verdict();
  end
endmodule // testbench
